/* File: design/gcs_pkg.sv */
// Package for the glitch-free two-input clock switchover: states, pin bundle, counts.
// Assumes a single 100 MHz sampling clock and input clocks far slower than it.
package gcs_pkg;

    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned CLK_PERIOD_NS    = 10;

    // Power-on hold: 12 ms per microfarad of delay capacitance
    localparam int unsigned POR_MS_PER_UF    = 12;
    localparam int unsigned POR_CAP_UF       = 1;
    localparam int unsigned POR_HOLD_MS      = POR_MS_PER_UF * POR_CAP_UF;
    localparam int unsigned POR_HOLD_CYCLES  = POR_HOLD_MS * 1000 * CLK_MHZ;

    // Pulse counts of each switchover phase; their sum stays far below 17
    localparam logic [2:0]  DRAIN_PULSES     = 3'h3;
    localparam logic [2:0]  HIGH_PULSES      = 3'h3;
    localparam logic [2:0]  LOW_PULSES       = 3'h3;
    localparam logic [4:0]  SWITCH_LIMIT     = 5'h11;

    // Sample cycles without an edge after which an input counts as stopped
    localparam logic [4:0]  STOP_CYCLES      = 5'h10;

    localparam logic        OUT_RESET        = 1'b0;
    localparam logic        CUR_RESET        = 1'b0;

    typedef enum logic [4:0] {
        ST_POR   = 5'h01,
        ST_RUN   = 5'h02,
        ST_DRAIN = 5'h04,
        ST_HIGH  = 5'h08,
        ST_LOW   = 5'h10
    } gcs_state_t;

    typedef struct packed {
        logic sel;
        logic cap;
        logic amp1;
        logic amp0;
        logic lvl1;
        logic lvl0;
    } gcs_pins_t;

endpackage

/* File: design/gcs_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is a level; no bit is read between the two stages.
`timescale 1ns/1ps
module gcs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

/* File: design/gcs_switchover.sv */
// Glitch-free two-input clock selector with fail-safe hold and power-on hold.
// Input clocks, select, bypass strap and amplitude flags are sampled by i_clk.
`timescale 1ns/1ps

module gcs_switchover #(
    parameter int unsigned P_POR_CYCLES = gcs_pkg::POR_HOLD_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_clock_in_zero,
    input  wire logic i_clock_in_one,
    input  wire logic i_amp_ok_zero,
    input  wire logic i_amp_ok_one,
    input  wire logic i_select,
    input  wire logic i_delay_cap_pin,
    output logic      o_clock_out,
    output logic      o_active_input,
    output logic      o_switching,
    output logic      o_ready
);
    logic                rst_meta_q;
    logic                rst_sync_q;
    logic                rst_n;
    gcs_pkg::gcs_pins_t  pins_raw;
    gcs_pkg::gcs_pins_t  pins_s;
    logic [1:0]          lvl_s;
    logic [1:0]          amp_s;
    logic [1:0]          prev_lvl_q;
    logic [1:0]          rise;
    logic [1:0]          fall;
    logic [4:0]          idle_q [2];
    logic [4:0]          idle_d [2];
    gcs_pkg::gcs_state_t state_q;
    gcs_pkg::gcs_state_t state_d;
    logic                cur_q;
    logic                cur_d;
    logic                out_q;
    logic                out_d;
    logic [2:0]          pcnt_q;
    logic [2:0]          pcnt_d;
    logic [31:0]         por_q;
    logic [31:0]         por_d;
    logic                busy_q;
    logic                ready_q;
    logic                cur_lvl;
    logic                cur_ok;
    logic                tgt_fall;
    logic                bypass;

    // Reset asserts at once and releases through two flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    assign pins_raw = '{sel:  i_select,
                        cap:  i_delay_cap_pin,
                        amp1: i_amp_ok_one,
                        amp0: i_amp_ok_zero,
                        lvl1: i_clock_in_one,
                        lvl0: i_clock_in_zero};

    gcs_sync #(
        .W ($bits(gcs_pkg::gcs_pins_t))
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (rst_n),
        .i_d       (pins_raw),
        .o_q       (pins_s)
    );

    function automatic logic pick(input logic idx, input logic [1:0] v);
        pick = idx ? v[1] : v[0];
    endfunction

    assign lvl_s    = {pins_s.lvl1, pins_s.lvl0};
    assign amp_s    = {pins_s.amp1, pins_s.amp0};
    assign rise     = lvl_s & ~prev_lvl_q;
    assign fall     = prev_lvl_q & ~lvl_s;
    assign bypass   = pins_s.cap;
    assign cur_lvl  = pick(cur_q, lvl_s);
    // A slowly failing but still toggling input keeps cur_ok high and passes as is
    assign cur_ok   = pick(cur_q, amp_s) && (idle_q[cur_q] != gcs_pkg::STOP_CYCLES);
    assign tgt_fall = pick(~cur_q, fall);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (rise[i] || fall[i]) begin
                idle_d[i] = 5'h00;
            end else if (idle_q[i] == gcs_pkg::STOP_CYCLES) begin
                idle_d[i] = idle_q[i];
            end else begin
                idle_d[i] = idle_q[i] + 5'h01;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        out_d   = out_q;
        pcnt_d  = pcnt_q;
        por_d   = por_q;
        case (state_q)
            gcs_pkg::ST_POR: begin
                out_d = 1'b0;
                if (por_q >= 32'(P_POR_CYCLES - 1)) begin
                    state_d = gcs_pkg::ST_RUN;
                    cur_d   = pins_s.sel;
                end else begin
                    por_d = por_q + 32'h1;
                end
            end
            gcs_pkg::ST_RUN: begin
                if (bypass) begin
                    cur_d = pins_s.sel;
                    out_d = pick(pins_s.sel, lvl_s);
                end else if (pins_s.sel != cur_q) begin
                    pcnt_d = 3'h0;
                    if (cur_ok) begin
                        state_d = gcs_pkg::ST_DRAIN;
                        out_d   = cur_lvl;
                    end else if (out_q) begin
                        state_d = gcs_pkg::ST_HIGH;
                    end else begin
                        state_d = gcs_pkg::ST_LOW;
                    end
                end else begin
                    out_d = cur_ok ? cur_lvl : out_q;
                end
            end
            gcs_pkg::ST_DRAIN: begin
                if (!cur_ok) begin
                    // Source died mid-drain: finish as a failed-source switchover
                    pcnt_d  = 3'h0;
                    state_d = out_q ? gcs_pkg::ST_HIGH : gcs_pkg::ST_LOW;
                end else if (pick(cur_q, fall)) begin
                    out_d = 1'b0;
                    if (pcnt_q == gcs_pkg::DRAIN_PULSES - 3'h1) begin
                        pcnt_d  = 3'h0;
                        state_d = gcs_pkg::ST_LOW;
                    end else begin
                        pcnt_d = pcnt_q + 3'h1;
                    end
                end else begin
                    out_d = cur_lvl;
                end
            end
            gcs_pkg::ST_HIGH: begin
                out_d = 1'b1;
                // Leaving only on a target fall keeps the high part over half a period
                if (tgt_fall) begin
                    if (pcnt_q == gcs_pkg::HIGH_PULSES - 3'h1) begin
                        pcnt_d  = 3'h0;
                        out_d   = 1'b0;
                        state_d = gcs_pkg::ST_LOW;
                    end else begin
                        pcnt_d = pcnt_q + 3'h1;
                    end
                end
            end
            gcs_pkg::ST_LOW: begin
                out_d = 1'b0;
                if (tgt_fall) begin
                    if (pcnt_q == gcs_pkg::LOW_PULSES - 3'h1) begin
                        pcnt_d  = 3'h0;
                        cur_d   = ~cur_q;
                        state_d = gcs_pkg::ST_RUN;
                    end else begin
                        pcnt_d = pcnt_q + 3'h1;
                    end
                end
            end
            default: begin
                state_d = gcs_pkg::ST_POR;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_lvl_q <= 2'h0;
            idle_q[0]  <= 5'h00;
            idle_q[1]  <= 5'h00;
            state_q    <= gcs_pkg::ST_POR;
            cur_q      <= gcs_pkg::CUR_RESET;
            out_q      <= gcs_pkg::OUT_RESET;
            pcnt_q     <= 3'h0;
            por_q      <= 32'h0;
            busy_q     <= 1'b0;
            ready_q    <= 1'b0;
        end else begin
            prev_lvl_q <= lvl_s;
            idle_q[0]  <= idle_d[0];
            idle_q[1]  <= idle_d[1];
            state_q    <= state_d;
            cur_q      <= cur_d;
            out_q      <= out_d;
            pcnt_q     <= pcnt_d;
            por_q      <= por_d;
            busy_q     <= (state_d != gcs_pkg::ST_RUN) && (state_d != gcs_pkg::ST_POR);
            ready_q    <= (state_d != gcs_pkg::ST_POR);
        end
    end

    assign o_clock_out    = out_q;
    assign o_active_input = cur_q;
    assign o_switching    = busy_q;
    assign o_ready        = ready_q;

    // Target edges counted during a switchover, for the latency bound
    logic [4:0] tgt_edges_q;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgt_edges_q <= 5'h00;
        end else if (state_q == gcs_pkg::ST_RUN || state_q == gcs_pkg::ST_POR) begin
            tgt_edges_q <= 5'h00;
        end else if (pick(~cur_q, rise) && tgt_edges_q != 5'h1f) begin
            tgt_edges_q <= tgt_edges_q + 5'h01;
        end
    end

    wire run_req = (state_q == gcs_pkg::ST_RUN) && !bypass && (pins_s.sel != cur_q);

    sequence s_high_then_low;
        (state_q == gcs_pkg::ST_HIGH) ##1 (state_q == gcs_pkg::ST_LOW);
    endsequence

    sequence s_low_then_run;
        (state_q == gcs_pkg::ST_LOW) ##1 (state_q == gcs_pkg::ST_RUN);
    endsequence

    a_drain_entry: assert property (@(posedge i_clk) disable iff (!rst_n)
        run_req && cur_ok |=> state_q == gcs_pkg::ST_DRAIN && out_q == $past(cur_lvl))
        else $error("live source did not start with drain phase");
    a_low_hold_out: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_q == gcs_pkg::ST_LOW |-> !out_q)
        else $error("output not low during low hold");
    a_run_follows: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == gcs_pkg::ST_RUN && !bypass && pins_s.sel == cur_q && cur_ok)
        |=> out_q == $past(cur_lvl))
        else $error("output not following active clock");
    a_stuck_high: assert property (@(posedge i_clk) disable iff (!rst_n)
        run_req && !cur_ok && out_q |=> state_q == gcs_pkg::ST_HIGH && out_q)
        else $error("stuck high source not held high");
    a_high_to_low: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_high_then_low |-> !out_q && $past(out_q) && $past(tgt_fall))
        else $error("high hold did not end low on target fall");
    a_low_exit: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_low_then_run |-> cur_q != $past(cur_q) && $past(tgt_fall))
        else $error("low hold did not hand over to target");
    a_stuck_low: assert property (@(posedge i_clk) disable iff (!rst_n)
        run_req && !cur_ok && !out_q |=> state_q == gcs_pkg::ST_LOW)
        else $error("stuck low source not held low");
    a_failsafe_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == gcs_pkg::ST_RUN && !bypass && pins_s.sel == cur_q && !cur_ok)
        |=> $stable(out_q))
        else $error("output moved while source is dead");
    a_por_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_q == gcs_pkg::ST_POR |-> !out_q && !ready_q && !busy_q)
        else $error("activity during power-on hold");
    a_bypass_mux: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == gcs_pkg::ST_RUN && bypass)
        |=> cur_q == $past(pins_s.sel) && out_q == $past(pick(pins_s.sel, lvl_s)))
        else $error("bypass did not act as plain multiplexer");
    a_switch_bound: assert property (@(posedge i_clk) disable iff (!rst_n)
        tgt_edges_q <= gcs_pkg::SWITCH_LIMIT)
        else $error("switchover exceeded target cycle limit");
endmodule

/* File: tb/gcs_clk_src.sv */
// Partner model: one input clock source that can run or stop at a chosen level.
// Assumes it is stepped on the falling edge of the bench sampling clock.
`timescale 1ns/1ps
module gcs_clk_src #(
    parameter int HALF = 4
) (
    input  wire logic i_clk,
    input  wire logic i_run,
    input  wire logic i_stop_lvl,
    output logic      o_clk
);
    int cnt_q;

    initial begin
        o_clk = 1'b0;
        cnt_q = 0;
    end

    // Whole half periods while running, so every synced level lasts at least HALF cycles unless a stop drives i_stop_lvl at once and cuts it short
    always @(negedge i_clk) begin
        if (i_run) begin
            cnt_q = (cnt_q >= HALF - 1) ? 0 : cnt_q + 1;
            if (cnt_q == 0) begin
                o_clk <= ~o_clk;
            end
        end else begin
            cnt_q = 0;
            o_clk <= i_stop_lvl;
        end
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the glitch-free clock switchover.
// Assumes the partner clock sources in gcs_clk_src and a short power-on hold.
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, c0, c1, amp0, amp1, sel, cap, run0, run1, lvl0, lvl1;
    logic out, act, sw, rdy, prev;
    int   err_count  = 0;
    int   n_compared = 0;
    int   cyc        = 0;
    int   min_w      = 100;
    int   w          = 100;

    gcs_clk_src #(.HALF(4)) src0_u (.i_clk(clk), .i_run(run0), .i_stop_lvl(lvl0), .o_clk(c0));
    gcs_clk_src #(.HALF(5)) src1_u (.i_clk(clk), .i_run(run1), .i_stop_lvl(lvl1), .o_clk(c1));

    gcs_switchover #(.P_POR_CYCLES(8)) dut_u (
        .i_clk(clk), .i_reset_n(rst_n), .i_clock_in_zero(c0), .i_clock_in_one(c1),
        .i_amp_ok_zero(amp0), .i_amp_ok_one(amp1), .i_select(sel), .i_delay_cap_pin(cap),
        .o_clock_out(out), .o_active_input(act), .o_switching(sw), .o_ready(rdy)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc >= 6000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end

    // Shortest output pulse seen, to catch runts during a switchover
    always @(negedge clk) begin
        if (rdy === 1'b1) begin
            if (out !== prev) begin
                if (w < min_w) min_w = w;
                w = 1;
            end else begin
                w = w + 1;
            end
        end
        prev = out;
    end

    task automatic chk(input logic seen, input logic exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s: got %b expected %b", $time, msg, seen, exp);
        end
    endtask

    task automatic switch_to(input logic s, output logic first_out);
        int n;
        @(negedge clk) sel = s;
        n = 0;
        while (sw !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        first_out = out;
        chk(n < 8, 1'b1, "switch start");
        n = 0;
        while (sw !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n < 200, 1'b1, "switch end");
        chk(act, s, "active input");
    endtask

    task automatic follows();
        int   n;
        logic p;
        n = 0;
        p = out;
        repeat (60) begin
            @(negedge clk);
            if (out !== p) n++;
            p = out;
        end
        chk(n >= 8, 1'b1, "output follows target");
    endtask

    task automatic t_reset();
        int n;
        chk(out | sw | rdy | act, 1'b0, "outputs in reset");
        @(negedge clk) rst_n = 1'b1;
        n = 0;
        while (rdy !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 8 && n < 40, 1'b1, "power-on hold length");
        chk(act, 1'b0, "initial input");
    endtask

    task automatic t_normal();
        logic f;
        repeat (20) @(negedge clk);
        min_w = 100;
        switch_to(1'b1, f);
        follows();
        chk(min_w >= 4, 1'b1, "no runt in switch");
    endtask

    task automatic t_stuck(input logic lvl);
        logic f;
        @(negedge clk);
        if (lvl) begin
            run1 = 1'b0;
            lvl1 = 1'b1;
        end else begin
            run0 = 1'b0;
            lvl0 = 1'b0;
        end
        repeat (30) @(negedge clk);
        chk(out, lvl, "dead input holds");
        min_w = 100;
        switch_to(~act, f);
        chk(f, lvl, "first hold level");
        follows();
        chk(min_w >= 4, 1'b1, "stretched cycle halves");
        run0 = 1'b1;
        run1 = 1'b1;
    endtask

    task automatic t_amp();
        logic v, f;
        repeat (20) @(negedge clk);
        amp1 = 1'b0;
        repeat (20) @(negedge clk);
        v = out;
        repeat (20) @(negedge clk);
        chk(out, v, "weak input latches");
        min_w = 100;
        switch_to(1'b0, f);
        chk(f, v, "last valid level kept");
        follows();
        chk(min_w >= 4, 1'b1, "no runt after loss");
        amp1 = 1'b1;
    endtask

    // Source loses amplitude while it is still being drained
    task automatic t_drain_loss();
        int n;
        repeat (20) @(negedge clk);
        min_w = 100;
        @(negedge clk) sel = 1'b1;
        n = 0;
        while (sw !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        amp0 = 1'b0;
        chk(n < 8, 1'b1, "drain start");
        n = 0;
        while (sw !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n < 200, 1'b1, "cut drain ends");
        chk(act, 1'b1, "cut drain target");
        follows();
        chk(min_w >= 4, 1'b1, "no runt after cut drain");
        amp0 = 1'b1;
    endtask

    task automatic t_bypass();
        logic s;
        @(negedge clk) cap = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s = ~sel;
            @(negedge clk) sel = s;
            repeat (5) @(negedge clk);
            chk(act, s, "plain mux select");
            chk(sw, 1'b0, "no sequence in bypass");
        end
    endtask

    initial begin
        rst_n = 1'b0;
        sel   = 1'b0;
        cap   = 1'b0;
        amp0  = 1'b1;
        amp1  = 1'b1;
        run0  = 1'b1;
        run1  = 1'b1;
        lvl0  = 1'b0;
        lvl1  = 1'b0;
        prev  = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_normal();
        t_stuck(1'b1);
        t_stuck(1'b0);
        t_amp();
        t_drain_loss();
        t_bypass();
        finish_test();
    end
endmodule
